// >>> common/acm_pkg.sv
// Constants, code tables and register map of the serial-bus clock configuration block
package acm_pkg;

   // Register addresses on the control port
   localparam logic [7:0] ADDR_RATE_RATIO_CFG = 8'h14;
   localparam logic [7:0] ADDR_MON_STS = 8'h15;
   localparam logic [7:0] ADDR_CLOCK_SOURCE_CONFIG_CFG = 8'h16;

   // Reset values
   localparam logic [7:0] RST_RATE_RATIO_CFG = 8'h48;
   localparam logic [7:0] RST_MON_STS = 8'hff;
   localparam logic [7:0] RST_CLOCK_SOURCE_CONFIG_CFG = 8'h10;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Field positions
   localparam int RATE_MSB = 7;
   localparam int RATE_LSB = 4;
   localparam int RATIO_MSB = 3;
   localparam int RATIO_LSB = 0;
   localparam int ROOT_SEL_BIT = 7;
   localparam int SPEC_MODE_BIT = 6;
   localparam int MRATIO_MSB = 5;
   localparam int MRATIO_LSB = 3;
   localparam logic [7:0] CLOCK_SOURCE_CONFIG_WR_MASK = 8'hf8;

   // Code limits
   localparam logic [3:0] RATE_CODE_MAX = 4'h8;
   localparam logic [3:0] RATIO_CODE_MAX = 4'hc;
   localparam logic [3:0] CODE_INVALID = 4'hf;

   // Frame rate table: base rate times a multiplier per code
   localparam int FS48_BASE_HZ = 8000;
   localparam int FS44_BASE_HZ = 7350;
   localparam int FS_MULT [0:8] = '{1, 2, 3, 4, 6, 12, 24, 48, 96};

   // Bit clock to frame sync ratios per code
   localparam int BCLK_RATIO [0:12] =
      '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048};

   // Master clock to frame sync ratios and fixed master clock list in kHz
   localparam int MCLK_RATIO [0:7] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
   localparam int MCLK_KHZ [0:7] =
      '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};

   // System clock and measurement timing
   localparam int CLK_SYS_HZ = 100_000_000;
   localparam int CNT_W = 12;
   localparam int PERIOD_W = 20;
   localparam int RATE_TOL_DIV = 32;
   localparam int FRAME_TIMEOUT_US = 300;
   localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * (CLK_SYS_HZ / 1_000_000);
   localparam int ACC_W = 35;

   // Clock monitor states
   typedef enum logic [2:0] {
      MON_IDLE = 3'b001,
      MON_ARMED = 3'b010,
      MON_TRACK = 3'b100
   } acm_mon_e;

endpackage

// >>> common/acm_link_if.sv
// Per-frame bit count handed from the bit clock domain to the system domain
`timescale 1ns/1ns
`default_nettype none
interface acm_link_if;
   import acm_pkg::*;
   logic [CNT_W-1:0] bits_per_frame;
   logic frame_tgl;
   modport counter (output bits_per_frame, output frame_tgl);
   modport monitor (input bits_per_frame, input frame_tgl);
endinterface
`default_nettype wire

// >>> hdl/acm_bit_counter.sv
// Bit clock domain counter: bit clocks per frame, flagged by a toggle per frame
`timescale 1ns/1ns
`default_nettype none
module acm_bit_counter
   import acm_pkg::*;
(
   // Link clock and reset
   input wire logic clk_bit,
   input wire logic rst,
   // Frame sync pin level
   input wire logic frame_sync_in,
   // Handoff to system domain
   acm_link_if.counter link
);

   logic fs_meta_ff;
   logic fs_sync_ff;
   logic fs_prev_ff;
   logic [CNT_W-1:0] bit_cnt_ff;
   logic [CNT_W-1:0] word_ff;
   logic tgl_ff;
   logic fs_rise;
   logic cnt_full;

   assign fs_rise = fs_sync_ff & ~fs_prev_ff;
   assign cnt_full = &bit_cnt_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sync passes two flops before the edge detector looks at it
   always_ff @(posedge clk_bit or posedge rst)
   begin
      if (rst)
      begin
         fs_meta_ff <= 1'b0;
         fs_sync_ff <= 1'b0;
         fs_prev_ff <= 1'b0;
      end
      else
      begin
         fs_meta_ff <= frame_sync_in;
         fs_sync_ff <= fs_meta_ff;
         fs_prev_ff <= fs_sync_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // count per frame: word held a whole frame, so the other side reads it stable
   always_ff @(posedge clk_bit or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_ff <= '0;
         word_ff <= '0;
         tgl_ff <= 1'b0;
      end
      else if (fs_rise)
      begin
         bit_cnt_ff <= '0;
         word_ff <= cnt_full ? bit_cnt_ff : bit_cnt_ff + 1'b1;
         tgl_ff <= ~tgl_ff;
      end
      else if (!cnt_full)
      begin
         bit_cnt_ff <= bit_cnt_ff + 1'b1; // Saturates on a frame that is far too long
      end
   end

   assign link.bits_per_frame = word_ff;
   assign link.frame_tgl = tgl_ff;

endmodule
`default_nettype wire

// >>> hdl/acm_clock_cfg_monitor.sv
// Serial-bus clock configuration registers, bit clock generator and clock monitor
//
// What this block does
// - Holds 4-bit programmed frame rate code in bits 7:4, reset 4.
// - Holds 4-bit programmed bit clock ratio code in bits 3:0, reset 8.
// - Reports detected frame rate code; 15 means no valid rate.
// - Status byte reads 0xff from reset until a stable measurement exists.
// - Target auto mode, PLL off: root source bit picks bit clock or master clock.
// - Auto mode: spec bit picks fixed frequency list or multiple of frame sync.
// - 3-bit master clock ratio field, reset 2, ratios 64 to 2304.
// - One rate code covers both families; family chosen by a separate input.
// - Controller select: 0 takes clocks as inputs, 1 drives both out.
// - PLL disable: 0 keeps PLL on; root source matters only when 1.
// - Fixed master clock list codes 0 to 7, 12 to 24.576 MHz.
`timescale 1ns/1ns
`default_nettype none
module acm_clock_cfg_monitor
   import acm_pkg::*;
#(
   parameter int TIMEOUT_CYC = FRAME_TIMEOUT_CYC
)
(
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bit clock pin used as the link clock
   input wire logic clk_bit,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata_ff,
   // Configuration levels from neighbouring registers
   input wire logic controller_target_select,
   input wire logic auto_clock_enable,
   input wire logic auto_setup_pll_disable,
   input wire logic fs_family_44k1,
   input wire logic [2:0] master_clock_frequency_code,
   // Frame sync and bit clock pins
   input wire logic frame_sync_in,
   output logic bclk_out_ff,
   output logic bclk_oe_ff,
   output logic frame_sync_out_ff,
   output logic frame_sync_oe_ff,
   // Clock tree selections
   output logic root_from_mclk_ff,
   output logic pll_enabled_ff,
   output logic mclk_spec_by_ratio_ff,
   output logic [11:0] mclk_fs_ratio_ff,
   output logic [14:0] mclk_ref_khz_ff
);

   acm_link_if link ();

   logic [7:0] rate_ratio_cfg_ff;
   logic [7:0] clock_source_config_cfg_ff;
   logic [7:0] mon_sts_ff;
   logic tgl_meta_ff;
   logic tgl_sync_ff;
   logic tgl_seen_ff;
   logic [PERIOD_W-1:0] period_ff;
   logic [7:0] prev_meas_ff;
   acm_mon_e mon_state_ff;
   acm_mon_e nxt_mon_state;
   logic [ACC_W-1:0] acc_ff;
   logic [11:0] bit_idx_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Code lookups; the tables are constants, the loops unroll
   function automatic logic [3:0] rate_code(input logic [PERIOD_W-1:0] per);
      logic [3:0] code;
      int p48;
      int p44;
      code = CODE_INVALID;
      for (int k = 0; k <= int'(RATE_CODE_MAX); k++)
      begin
         p48 = CLK_SYS_HZ / (FS48_BASE_HZ * FS_MULT[k]);
         p44 = CLK_SYS_HZ / (FS44_BASE_HZ * FS_MULT[k]);
         if (int'(per) >= p48 - p48 / RATE_TOL_DIV && int'(per) <= p44 + p44 / RATE_TOL_DIV)
         begin
            code = 4'(k);
         end
      end
      return code;
   endfunction

   function automatic logic [3:0] ratio_code(input logic [CNT_W-1:0] bits);
      logic [3:0] code;
      code = CODE_INVALID;
      for (int k = 0; k <= int'(RATIO_CODE_MAX); k++)
      begin
         if (int'(bits) == BCLK_RATIO[k])
         begin
            code = 4'(k);
         end
      end
      return code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bit clock domain counter
   acm_bit_counter u_bit_counter (
      .clk_bit(clk_bit),
      .rst(rst),
      .frame_sync_in(frame_sync_in),
      .link(link.counter)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire sel_rate = (reg_addr == ADDR_RATE_RATIO_CFG);
   wire sel_sts = (reg_addr == ADDR_MON_STS);
   wire sel_src = (reg_addr == ADDR_CLOCK_SOURCE_CONFIG_CFG);
   wire [7:0] rd_mux = sel_rate ? rate_ratio_cfg_ff :
                       sel_sts ? mon_sts_ff :
                       sel_src ? clock_source_config_cfg_ff : READ_ZERO;

   // rate field and ratio field are plain storage, reserved codes kept as written
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rate_ratio_cfg_ff <= RST_RATE_RATIO_CFG;
         clock_source_config_cfg_ff <= RST_CLOCK_SOURCE_CONFIG_CFG;
      end
      else if (reg_wr_en && sel_rate)
      begin
         rate_ratio_cfg_ff <= reg_wdata;
      end
      else if (reg_wr_en && sel_src)
      begin
         // ratio field written; low reserved bits stay zero
         clock_source_config_cfg_ff <= reg_wdata & CLOCK_SOURCE_CONFIG_WR_MASK;
      end
   end

   // Read data registered one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         reg_rdata_ff <= READ_ZERO;
      else if (reg_rd_en)
         reg_rdata_ff <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame toggle crossing: meta flop feeds only the sync flop
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tgl_meta_ff <= 1'b0;
         tgl_sync_ff <= 1'b0;
         tgl_seen_ff <= 1'b0;
      end
      else
      begin
         tgl_meta_ff <= link.frame_tgl;
         tgl_sync_ff <= tgl_meta_ff;
         tgl_seen_ff <= tgl_sync_ff;
      end
   end

   wire frame_evt = tgl_sync_ff ^ tgl_seen_ff;
   wire timed_out = (period_ff >= PERIOD_W'(TIMEOUT_CYC));
   wire [PERIOD_W-1:0] period_len = period_ff + 1'b1;
   // rate from frame period, ratio from bits per frame; one code spans both families
   wire [7:0] meas = {rate_code(period_len), ratio_code(link.bits_per_frame)};

   // Frame period in system cycles, held at the timeout mark when frames stop
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         period_ff <= '0;
      else if (frame_evt)
         period_ff <= '0;
      else if (!timed_out)
         period_ff <= period_ff + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Monitor sequencing: the first period after idle is partial, so it is not trusted
   always_comb
   begin
      nxt_mon_state = mon_state_ff;
      case (mon_state_ff)
         MON_IDLE:
            if (frame_evt)
               nxt_mon_state = MON_ARMED;
         MON_ARMED:
            if (timed_out)
               nxt_mon_state = MON_IDLE;
            else if (frame_evt)
               nxt_mon_state = MON_TRACK;
         MON_TRACK:
            if (timed_out)
               nxt_mon_state = MON_IDLE;
         default:
            nxt_mon_state = MON_IDLE;
      endcase
   end

   // status starts all ones and falls back to all ones when frames stop
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         mon_state_ff <= MON_IDLE;
         mon_sts_ff <= RST_MON_STS;
         prev_meas_ff <= RST_MON_STS;
      end
      else
      begin
         mon_state_ff <= nxt_mon_state;
         if (timed_out)
            mon_sts_ff <= RST_MON_STS;
         // status updates only on two equal readings in a row
         else if (frame_evt && mon_state_ff == MON_TRACK && meas == prev_meas_ff)
            mon_sts_ff <= meas;
         if (frame_evt)
            prev_meas_ff <= meas;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit clock rate: base times multiplier times ratio; family from input
   wire [3:0] rate_cd = rate_ratio_cfg_ff[RATE_MSB:RATE_LSB];
   wire [3:0] ratio_cd = rate_ratio_cfg_ff[RATIO_MSB:RATIO_LSB];
   wire codes_ok = (rate_cd <= RATE_CODE_MAX) && (ratio_cd <= RATIO_CODE_MAX);
   wire [3:0] rate_ix = codes_ok ? rate_cd : 4'h0;
   wire [3:0] ratio_ix = codes_ok ? ratio_cd : 4'h0;
   wire [ACC_W-1:0] base_hz = fs_family_44k1 ? ACC_W'(FS44_BASE_HZ) : ACC_W'(FS48_BASE_HZ);
   wire [ACC_W-1:0] frame_bits = ACC_W'(BCLK_RATIO[ratio_ix]);
   wire [ACC_W-1:0] edge_hz = ACC_W'(base_hz * ACC_W'(FS_MULT[rate_ix]) * frame_bits * 2);
   wire [ACC_W-1:0] acc_sum = acc_ff + edge_hz;
   wire [ACC_W-1:0] clk_hz = ACC_W'(CLK_SYS_HZ);
   // Too fast for the system clock: toggle on every edge, the fastest we can give
   wire too_fast = (edge_hz >= clk_hz);
   wire bclk_step = too_fast || (acc_sum >= clk_hz);
   // controller mode drives both clocks, target mode leaves them as inputs
   wire gen_on = controller_target_select && codes_ok;
   wire bclk_fall = gen_on && bclk_step && bclk_out_ff;
   wire [11:0] idx_last = 12'(BCLK_RATIO[ratio_ix] - 1);

   // Phase accumulator on the system clock; leaves edge jitter of one system period
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         acc_ff <= '0;
      else if (!gen_on || too_fast)
         acc_ff <= '0;
      else if (bclk_step)
         acc_ff <= acc_sum - clk_hz;
      else
         acc_ff <= acc_sum;
   end

   // pin drivers; frame sync moves on the falling edge for host sampling on rising
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bclk_out_ff <= 1'b0;
         bclk_oe_ff <= 1'b0;
         frame_sync_out_ff <= 1'b0;
         frame_sync_oe_ff <= 1'b0;
         bit_idx_ff <= '0;
      end
      else
      begin
         bclk_oe_ff <= controller_target_select;
         frame_sync_oe_ff <= controller_target_select;
         if (!gen_on)
         begin
            bclk_out_ff <= 1'b0;
            frame_sync_out_ff <= 1'b0;
            bit_idx_ff <= '0;
         end
         else if (bclk_step)
         begin
            bclk_out_ff <= ~bclk_out_ff;
            if (bclk_fall)
            begin
               bit_idx_ff <= (bit_idx_ff >= idx_last) ? 12'h000 : bit_idx_ff + 1'b1;
               frame_sync_out_ff <= (bit_idx_ff >= idx_last);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock tree selections
   wire in_target_auto = !controller_target_select && auto_clock_enable;
   // root source honoured only with the PLL off in target auto mode
   wire root_mclk = in_target_auto && auto_setup_pll_disable && clock_source_config_cfg_ff[ROOT_SEL_BIT];
   // spec mode only counts in auto mode
   wire spec_ratio = auto_clock_enable && clock_source_config_cfg_ff[SPEC_MODE_BIT];
   // ratio applies in controller mode or with master clock as root
   wire [2:0] mratio_cd = clock_source_config_cfg_ff[MRATIO_MSB:MRATIO_LSB];
   wire use_mratio = controller_target_select || root_mclk;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         root_from_mclk_ff <= 1'b0;
         pll_enabled_ff <= 1'b1;
         mclk_spec_by_ratio_ff <= 1'b0;
         mclk_fs_ratio_ff <= '0;
         mclk_ref_khz_ff <= '0;
      end
      else
      begin
         root_from_mclk_ff <= root_mclk;
         // PLL runs unless auto mode has it disabled
         pll_enabled_ff <= !(auto_clock_enable && auto_setup_pll_disable);
         mclk_spec_by_ratio_ff <= spec_ratio;
         mclk_fs_ratio_ff <= use_mratio ? 12'(MCLK_RATIO[mratio_cd]) : 12'h000;
         // fixed list used in controller mode when not specified by ratio
         mclk_ref_khz_ff <= (controller_target_select && !spec_ratio) ?
                            15'(MCLK_KHZ[master_clock_frequency_code]) : 15'h0000;
      end
   end

endmodule
`default_nettype wire

// >>> dv/acm_clock_cfg_monitor_props.sv
// Concurrent checks on the ports of the clock configuration and monitor block
`timescale 1ns/1ns
`default_nettype none
module acm_clock_cfg_monitor_props
   import acm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata_ff,
   // Mode levels
   input wire logic controller_target_select,
   input wire logic auto_setup_pll_disable,
   // Pins and clock tree
   input wire logic bclk_out_ff,
   input wire logic bclk_oe_ff,
   input wire logic frame_sync_out_ff,
   input wire logic frame_sync_oe_ff,
   input wire logic root_from_mclk_ff
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Address decode kept as a named wire so the properties stay short
   wire logic unmapped = !(reg_addr inside {ADDR_RATE_RATIO_CFG, ADDR_MON_STS, ADDR_CLOCK_SOURCE_CONFIG_CFG});

   ////////////////////////////////////////////////////////////////////////////////
   property p_unmapped_zero;
      reg_rd_en && unmapped |=> reg_rdata_ff == READ_ZERO;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   property p_src_low_zero;
      reg_rd_en && reg_addr == ADDR_CLOCK_SOURCE_CONFIG_CFG |=> reg_rdata_ff[2:0] == 3'h0;
   endproperty
   a_src_low_zero: assert property (p_src_low_zero)
      else $error("clock source low bits not zero");
   property p_rd_hold;
      !reg_rd_en |=> $stable(reg_rdata_ff);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_wr_then_rd;
      reg_wr_en && !reg_rd_en && reg_addr == ADDR_RATE_RATIO_CFG
      ##1 reg_rd_en && !reg_wr_en && reg_addr == ADDR_RATE_RATIO_CFG
      |=> reg_rdata_ff == $past(reg_wdata, 2);
   endproperty
   a_wr_then_rd: assert property (p_wr_then_rd)
      else $error("rate ratio write not read back");
   property p_target_no_drive;
      !controller_target_select |=> !bclk_oe_ff && !frame_sync_oe_ff;
   endproperty
   a_target_no_drive: assert property (p_target_no_drive)
      else $error("pins driven in target mode");
   property p_ctl_drive;
      controller_target_select |=> bclk_oe_ff && frame_sync_oe_ff;
   endproperty
   a_ctl_drive: assert property (p_ctl_drive)
      else $error("pins not driven in controller mode");
   property p_target_quiet;
      !controller_target_select [*2] |-> !bclk_out_ff && !frame_sync_out_ff;
   endproperty
   a_target_quiet: assert property (p_target_quiet)
      else $error("generator running in target mode");
   property p_root_needs_pll_off;
      !auto_setup_pll_disable [*2] |-> !root_from_mclk_ff;
   endproperty
   a_root_needs_pll_off: assert property (p_root_needs_pll_off)
      else $error("root source moved with pll on");

   // Main scenarios reached
   c_oe: cover property ($rose(bclk_oe_ff));
   c_root: cover property ($rose(root_from_mclk_ff));
   c_fs: cover property ($rose(frame_sync_out_ff));
endmodule
`default_nettype wire

// >>> dv/acm_host_model.sv
// Behavioural audio host driving bit clock and frame sync in target mode
`timescale 1ns/1ns
`default_nettype none
module acm_host_model
(
   // Control from the bench
   input wire logic run,
   input wire logic [11:0] ratio,
   // Serial bus lines
   output logic bclk,
   output logic frame_sync
);
   int cnt;

   initial
   begin
      bclk = 1'b0;
      frame_sync = 1'b0;
      cnt = 0;
   end

   // host clocks: 15 ns bit clock, one-bit frame pulse every ratio bits
   always
   begin
      if (run)
      begin
         #7 bclk = 1'b1;
         #8 bclk = 1'b0;
         // Launch on the falling edge so the device samples a settled level
         frame_sync = (cnt == 0);
         cnt = (cnt + 1 >= int'(ratio)) ? 0 : cnt + 1;
      end
      else
      begin
         // Clock stands still between runs; the undriven line wanders
         #15 frame_sync = ~frame_sync;
         cnt = 0;
      end
   end
endmodule
`default_nettype wire

// >>> dv/tb_acm_clock_cfg_monitor.sv
// Self-checking bench for the clock configuration and monitor block
`timescale 1ns/1ns
`default_nettype none
module tb_acm_clock_cfg_monitor
   import acm_pkg::*;
;
   typedef struct {logic [7:0] addr, wdata, exp;} acm_row_s;
   // Timeout must clear the longest frame used here (about 2268 cycles at 44.1 kHz)
   localparam int TMO = 3000;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, q;
   logic controller_target_select = 1'b0, auto_clock_enable = 1'b1;
   logic auto_setup_pll_disable = 1'b0, fs_family_44k1 = 1'b0, host_run = 1'b0;
   logic [2:0] master_clock_frequency_code = 3'h2;
   logic [11:0] host_ratio = 12'd96;
   logic [7:0] reg_rdata_ff;
   logic bclk_out_ff, bclk_oe_ff, frame_sync_out_ff, frame_sync_oe_ff;
   logic root_from_mclk_ff, pll_enabled_ff, mclk_spec_by_ratio_ff;
   logic [11:0] mclk_fs_ratio_ff;
   logic [14:0] mclk_ref_khz_ff;
   wire logic host_bclk, host_fs, clk_bit, frame_sync_in;
   int err_count = 0, n_checks = 0;
   acm_row_s rows [8] = '{
      '{8'h14, 8'h35, 8'h35}, '{8'h14, 8'hff, 8'hff}, '{8'h14, 8'h48, 8'h48},
      '{8'h16, 8'hff, 8'hf8}, '{8'h16, 8'h07, 8'h00}, '{8'h16, 8'h10, 8'h10},
      '{8'h15, 8'h00, 8'hff}, '{8'h17, 8'haa, 8'h00}};
   int t_ratio [4] = '{96, 0, 128, 100};
   logic [7:0] t_sts [4] = '{8'h85, 8'hff, 8'hf6, 8'hff};

   // Wire levels: whoever enables its driver owns the line
   assign clk_bit = bclk_oe_ff ? bclk_out_ff : host_bclk;
   assign frame_sync_in = frame_sync_oe_ff ? frame_sync_out_ff : host_fs;
   always #5 clk_sys = ~clk_sys;

   acm_clock_cfg_monitor #(.TIMEOUT_CYC(TMO)) uut (.clk_sys, .rst, .clk_bit, .reg_addr,
      .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata_ff, .controller_target_select,
      .auto_clock_enable, .auto_setup_pll_disable, .fs_family_44k1,
      .master_clock_frequency_code, .frame_sync_in, .bclk_out_ff, .bclk_oe_ff,
      .frame_sync_out_ff, .frame_sync_oe_ff, .root_from_mclk_ff, .pll_enabled_ff,
      .mclk_spec_by_ratio_ff, .mclk_fs_ratio_ff, .mclk_ref_khz_ff);
   acm_host_model host (.run(host_run), .ratio(host_ratio), .bclk(host_bclk),
      .frame_sync(host_fs));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      #1 d = reg_rdata_ff;
   endtask
   // Write, then read the same place on the very next cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      #1 r = reg_rdata_ff;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(16'(d), 16'(e));
   endtask
   // Polls status with a bound: three frames at 44.1 kHz fit well inside
   task automatic waitsts(input logic [7:0] e);
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 6000 && d !== e; i++)
         rd(ADDR_MON_STS, d);
      chk(16'(d), 16'(e));
   endtask
   task automatic done(input string s);
      $display("test done: %s", s);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(1);
      rdchk(ADDR_RATE_RATIO_CFG, RST_RATE_RATIO_CFG);
      rdchk(ADDR_MON_STS, RST_MON_STS);
      rdchk(ADDR_CLOCK_SOURCE_CONFIG_CFG, RST_CLOCK_SOURCE_CONFIG_CFG);
      chk(16'(pll_enabled_ff), 16'h1);
      chk(16'(bclk_oe_ff), 16'h0);
      done("reset");
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata, q);
         chk(16'(q), 16'(rows[i].exp));
      end
      done("register rows");
      @(posedge clk_sys);
      controller_target_select <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_sys);
         master_clock_frequency_code <= 3'(i);
         wr(ADDR_CLOCK_SOURCE_CONFIG_CFG, {2'b00, 3'(i), 3'b000}, q);
         cyc(3);
         chk(16'(mclk_fs_ratio_ff), 16'(MCLK_RATIO[i]));
         chk(16'(mclk_ref_khz_ff), 16'(MCLK_KHZ[i]));
      end
      wr(ADDR_CLOCK_SOURCE_CONFIG_CFG, 8'h50, q);
      cyc(3);
      chk(16'(mclk_spec_by_ratio_ff), 16'h1);
      chk(16'(mclk_ref_khz_ff), 16'h0);
      done("master clock decode");
      // Mid-run reset while the generator runs must undo the written fields
      @(posedge clk_sys);
      rst <= 1'b1;
      cyc(3);
      chk(16'({bclk_out_ff, frame_sync_oe_ff}), 16'h0);
      @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(ADDR_CLOCK_SOURCE_CONFIG_CFG, RST_CLOCK_SOURCE_CONFIG_CFG);
      chk(16'(mclk_spec_by_ratio_ff), 16'h0);
      done("mid-run reset");
      @(posedge clk_sys);
      controller_target_select <= 1'b0;
      auto_setup_pll_disable <= 1'b1;
      wr(ADDR_CLOCK_SOURCE_CONFIG_CFG, 8'h90, q);
      cyc(3);
      chk(16'(root_from_mclk_ff), 16'h1);
      chk(16'(mclk_fs_ratio_ff), 16'd384);
      chk(16'(pll_enabled_ff), 16'h0);
      // Without automatic setup neither the root source nor the PLL bit counts
      @(posedge clk_sys);
      auto_clock_enable <= 1'b0;
      cyc(3);
      chk(16'(root_from_mclk_ff), 16'h0);
      chk(16'(pll_enabled_ff), 16'h1);
      @(posedge clk_sys);
      auto_clock_enable <= 1'b1;
      @(posedge clk_sys);
      auto_setup_pll_disable <= 1'b0;
      cyc(3);
      chk(16'(root_from_mclk_ff), 16'h0);
      chk(16'(pll_enabled_ff), 16'h1);
      @(posedge clk_sys);
      auto_setup_pll_disable <= 1'b1;
      wr(ADDR_CLOCK_SOURCE_CONFIG_CFG, 8'h10, q);
      cyc(3);
      chk(16'(root_from_mclk_ff), 16'h0);
      done("root source");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys);
         host_run <= (t_ratio[i] != 0);
         host_ratio <= 12'(t_ratio[i]);
         waitsts(t_sts[i]);
      end
      done("target monitor");
      @(posedge clk_sys);
      host_run <= 1'b0;
      controller_target_select <= 1'b1;
      for (int f = 0; f < 2; f++)
      begin
         @(posedge clk_sys);
         fs_family_44k1 <= f[0];
         wr(ADDR_RATE_RATIO_CFG, 8'h44, q);
         waitsts(8'h44);
         chk(16'({bclk_oe_ff, frame_sync_oe_ff}), 16'h3);
         wr(ADDR_RATE_RATIO_CFG, 8'h9f, q);
         waitsts(8'hff);
      end
      done("controller generation");
      results();
   end

   // Watchdog: the full run needs about two fifths of this span
   initial
   begin
      #600000;
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      results();
   end
endmodule

bind acm_clock_cfg_monitor acm_clock_cfg_monitor_props chk_props (.clk_sys, .rst, .reg_addr,
   .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata_ff, .controller_target_select,
   .auto_setup_pll_disable, .bclk_out_ff, .bclk_oe_ff, .frame_sync_out_ff,
   .frame_sync_oe_ff, .root_from_mclk_ff);
`default_nettype wire
